// *** hw/rcb_pkg.sv ***
// package of offsets, fields, reset values and types for the readout control register bank
package rcb_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [15:0] RCB_OFF_READOUT_STATUS  = 16'hEF04;
	localparam logic [15:0] RCB_OFF_GEO_SLOT        = 16'hEF08;
	localparam logic [15:0] RCB_OFF_MULTICAST       = 16'hEF0C;
	localparam logic [15:0] RCB_OFF_RELOCATION      = 16'hEF10;
	localparam logic [15:0] RCB_OFF_INT_VECTOR      = 16'hEF14;
	localparam logic [15:0] RCB_OFF_INT_THRESHOLD   = 16'hEF18;
	localparam logic [15:0] RCB_OFF_AGGR_PER_BLT    = 16'hEF1C;
	localparam logic [15:0] RCB_OFF_SCRATCH         = 16'hEF20;
	localparam logic [15:0] RCB_OFF_SOFT_RESET      = 16'hEF24;
	localparam logic [15:0] RCB_OFF_MEMORY_CLEAR    = 16'hEF28;
	localparam logic [15:0] RCB_OFF_CONFIG_RELOAD   = 16'hEF34;

	// ------------------------------------------------------------
	// field positions and widths
	// ------------------------------------------------------------
	localparam int RCB_STS_EVENT_READY = 0;
	localparam int RCB_STS_BUFFER_FULL = 1;
	localparam int RCB_STS_BUS_ERROR   = 2;
	localparam int RCB_GEO_W           = 5;
	localparam int RCB_MCST_ADDR_W     = 8;
	localparam int RCB_RELOC_W         = 16;
	localparam int RCB_COUNT_W         = 10;
	localparam int RCB_IRQ_LEVEL_W     = 3;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [4:0]  RCB_RST_GEO       = 5'h00;
	localparam logic [7:0]  RCB_RST_MCST_ADDR = 8'h00;
	localparam logic [15:0] RCB_RST_RELOC     = 16'h0000;
	localparam logic [31:0] RCB_RST_VECTOR    = 32'h0000_0000;
	localparam logic [9:0]  RCB_RST_THRESHOLD = 10'h000;
	localparam logic [9:0]  RCB_RST_AGGR      = 10'h000;
	localparam logic [31:0] RCB_RST_SCRATCH   = 32'h0000_0000;

	// daisy chain role encoding
	typedef enum logic [1:0] {
		RCB_CHAIN_DISABLED     = 2'b00,
		RCB_CHAIN_LAST         = 2'b01,
		RCB_CHAIN_FIRST        = 2'b10,
		RCB_CHAIN_INTERMEDIATE = 2'b11
	} rcb_chain_role_t;

endpackage : rcb_pkg

// *** hw/rcb_register_bank.sv ***
// readout control register bank: status, slot id, multicast, relocation, interrupt and commands
`timescale 1ns/1ns
// Notes on behaviour
// - status bit 0 is one while at least one stored event awaits readout.
// - status bit 1 is one while the output buffer is full.
// - status bit 2 sets on bus error, unsupported access or early-ended aligned transfer.
// - reading the readout status register clears the bus error flag.
// - with geographic crate, slot number comes read-only from backplane into event header.
// - otherwise slot id is writable, defaults zero; host writes it before chained transfers.
// - multicast and chained cycles match address top bits against written eight-bit field.
// - two-bit chain role: 00 disabled, 01 last, 10 first, 11 intermediate.
// - with relocation enabled, base address bits 31..16 come from relocation field.
// - programmed 32-bit vector is driven on data during interrupt acknowledge.
// - with interrupts enabled, request raised while stored events exceed threshold.
// - each block transfer carries at most the programmed number of complete aggregates.
// - scratch word reads back the last written value.
// - any write to soft reset location returns every register to default.
// - backplane system reset also returns every register to default.
// - any write to clear location empties memories and zeroes count, size, occupancy.
// - the same memory clear happens at the start of every acquisition run.
// - memory clear is also accepted as a hardware signal on differential io.
// - any write to reload location soft resets, reloads rom and reconfigures pll.
// - bus interrupts only when level field nonzero; one to seven selects level.
module rcb_register_bank
	import rcb_pkg::*;
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	// register port: one-cycle strobes, byte offset, write data
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [15:0] reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	output logic      [31:0] reg_rdata_out,
	output logic             reg_rvalid_out,
	output logic             reg_unsupported_out,
	// crate and backplane pins (asynchronous)
	input  wire logic        geo_crate_in,
	input  wire logic [4:0]  geo_slot_in,
	input  wire logic        sysreset_in,
	input  wire logic        hw_clear_in,
	// acquisition core state (same clock)
	input  wire logic [9:0]  events_stored_in,
	input  wire logic        buffer_full_in,
	input  wire logic        bus_error_in,
	input  wire logic        early_end_in,
	input  wire logic        run_start_in,
	input  wire logic        hw_clear_enable_in,
	input  wire logic [2:0]  irq_level_in,
	input  wire logic        relocation_enable_in,
	input  wire logic [15:0] switch_base_in,
	// bus address matching and acknowledge
	input  wire logic [31:0] bus_addr_in,
	input  wire logic        intack_in,
	// block transfer aggregate counting (same clock)
	input  wire logic        blt_start_in,
	input  wire logic        aggregate_done_in,
	// outputs towards the board
	output logic      [4:0]  header_geo_slot_identifier_out,
	output logic      [15:0] base_address_out,
	output logic             base_match_out,
	output logic             mcst_match_out,
	output logic      [1:0]  chain_role_out,
	output logic      [31:0] intack_data_out,
	output logic             intack_data_oe_out,
	output logic             irq_out,
	output logic      [2:0]  irq_level_out,
	output logic      [9:0]  aggr_limit_out,
	output logic             blt_stop_out,
	output logic             memory_clear_out,
	output logic             config_reload_out
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  sysrst_sync;
		logic [2:0]  clr_sync;
		logic [5:0]  geo_sync0;
		logic [5:0]  geo_sync1;
		logic [5:0]  geo_sync2;
		logic        sysrst_level;
		logic        clr_level;
		logic        clr_prev;
		logic        geo_crate;
		logic [4:0]  geo_pins;
		logic        bus_err_flag;
		logic [4:0]  slot_id;
		logic [7:0]  mcst_addr;
		logic [1:0]  chain_role;
		logic [15:0] reloc;
		logic [31:0] vector;
		logic [9:0]  threshold;
		logic [9:0]  aggr_limit;
		logic [31:0] scratch;
		logic [9:0]  aggr_count;
		logic [31:0] rdata;
		logic        rvalid;
		logic        unsupported;
		logic [4:0]  header_id;
		logic [15:0] base;
		logic        base_match;
		logic        mcst_match;
		logic [31:0] ack_data;
		logic        ack_oe;
		logic        irq;
		logic [2:0]  irq_level;
		logic        blt_stop;
		logic        mem_clear;
		logic        reload;
	} rcb_state_t;

	rcb_state_t r;
	rcb_state_t next_r;

	// ------------------------------------------------------------
	// field notes and limitations
	// ------------------------------------------------------------
	// pin stages
	//   sysrst_sync, clr_sync: three-flop chains
	//   geo_sync0..2: crate strap and slot pins
	//   a level is taken only when the second
	//   and third stages agree, so a glitch of
	//   one cycle never reaches the decisions

	// settled levels
	//   sysrst_level holds registers at default
	//   clr_level feeds the pin clear edge
	//   clr_prev remembers the last level
	//   geo_crate picks backplane slot or register

	// host registers
	//   slot_id: writable only without straps
	//   mcst_addr, chain_role: multicast setup
	//   reloc: base bits when relocation is on
	//   vector: word driven on acknowledge
	//   threshold: events above it interrupt
	//   aggr_limit: aggregates per transfer
	//   scratch: plain read and write word

	// transfer bookkeeping
	//   aggr_count saturates so it never wraps
	//   back below the limit in a long transfer

	// registered answers
	//   rdata is zero outside a read answer, so
	//   a host that samples late sees zero, not
	//   a stale word
	//   unsupported pulses with the answer and
	//   also sets the status error flag

	// board side levels
	//   base and matches lag the bus address by
	//   one cycle; the bus decoder must allow it
	//   ack_oe needs a pending request the cycle
	//   before, so a stray acknowledge stays off

	// command pulses
	//   mem_clear and reload last one cycle
	//   the acquisition core must catch them
	//   on the very next edge

	// reset
	//   the async reset loads constants only;
	//   straps are picked up by the stages
	//   a few cycles after release

	// limitations
	//   both strobes in one cycle are not
	//   supported; the write decode wins the
	//   error flag and the read still answers
	//   the pin clear needs a rising edge, so a
	//   pin held high clears only once
	//   a backplane reset held high keeps every
	//   register at default, writes are lost
	//   the interrupt follows the level field
	//   only; an optical enable is not seen here

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// synchronisers feed only their next stage; decisions use stages two and three
	always_comb begin
		logic        wr_known;
		logic        rd_known;
		logic        soft_rst;
		logic        sys_rst;
		logic        clr_edge;
		logic        geo_mode;
		logic [31:0] rd_word;
		wr_known = 1'b0;
		rd_known = 1'b0;
		soft_rst = 1'b0;
		sys_rst  = 1'b0;
		clr_edge = 1'b0;
		geo_mode = 1'b0;
		rd_word  = 32'h0000_0000;
		next_r   = r;

		// three-stage pin inputs; a change counts when stages two and three agree
		next_r.sysrst_sync = {r.sysrst_sync[1:0], sysreset_in};
		next_r.clr_sync    = {r.clr_sync[1:0], hw_clear_in};
		next_r.geo_sync0   = {geo_crate_in, geo_slot_in};
		next_r.geo_sync1   = r.geo_sync0;
		next_r.geo_sync2   = r.geo_sync1;
		if (r.sysrst_sync[2] == r.sysrst_sync[1]) begin
			next_r.sysrst_level = r.sysrst_sync[2];
		end
		if (r.clr_sync[2] == r.clr_sync[1]) begin
			next_r.clr_level = r.clr_sync[2];
		end
		if (r.geo_sync2 == r.geo_sync1) begin
			next_r.geo_crate = r.geo_sync2[5];
			next_r.geo_pins  = r.geo_sync2[4:0];
		end
		next_r.clr_prev = r.clr_level;
		clr_edge        = r.clr_level & ~r.clr_prev;
		sys_rst         = r.sysrst_level;
		geo_mode        = r.geo_crate;

		// read decode; unmapped and write-only locations read zero and report unsupported
		if (reg_addr_in == RCB_OFF_READOUT_STATUS) begin
			rd_known = 1'b1;
			rd_word[RCB_STS_EVENT_READY] = (events_stored_in != 10'h000);
			rd_word[RCB_STS_BUFFER_FULL] = buffer_full_in;
			rd_word[RCB_STS_BUS_ERROR]   = r.bus_err_flag;
		end else if (reg_addr_in == RCB_OFF_GEO_SLOT) begin
			rd_known = 1'b1;
			rd_word[RCB_GEO_W-1:0] = geo_mode ? r.geo_pins : r.slot_id;
		end else if (reg_addr_in == RCB_OFF_MULTICAST) begin
			rd_known = 1'b1;
			rd_word[9:0] = {r.chain_role, r.mcst_addr};
		end else if (reg_addr_in == RCB_OFF_RELOCATION) begin
			rd_known = 1'b1;
			rd_word[RCB_RELOC_W-1:0] = r.reloc;
		end else if (reg_addr_in == RCB_OFF_INT_VECTOR) begin
			rd_known = 1'b1;
			rd_word = r.vector;
		end else if (reg_addr_in == RCB_OFF_INT_THRESHOLD) begin
			rd_known = 1'b1;
			rd_word[RCB_COUNT_W-1:0] = r.threshold;
		end else if (reg_addr_in == RCB_OFF_AGGR_PER_BLT) begin
			rd_known = 1'b1;
			rd_word[RCB_COUNT_W-1:0] = r.aggr_limit;
		end else if (reg_addr_in == RCB_OFF_SCRATCH) begin
			rd_known = 1'b1;
			rd_word = r.scratch;
		end

		// write decode; reserved bits are dropped on the way in
		next_r.mem_clear = 1'b0;
		next_r.reload    = 1'b0;
		if (reg_wr_in) begin
			wr_known = 1'b1;
			if (reg_addr_in == RCB_OFF_GEO_SLOT) begin
				if (!geo_mode) begin
					next_r.slot_id = reg_wdata_in[RCB_GEO_W-1:0];
				end
			end else if (reg_addr_in == RCB_OFF_MULTICAST) begin
				next_r.mcst_addr  = reg_wdata_in[7:0];
				next_r.chain_role = reg_wdata_in[9:8];
			end else if (reg_addr_in == RCB_OFF_RELOCATION) begin
				next_r.reloc = reg_wdata_in[15:0];
			end else if (reg_addr_in == RCB_OFF_INT_VECTOR) begin
				next_r.vector = reg_wdata_in;
			end else if (reg_addr_in == RCB_OFF_INT_THRESHOLD) begin
				next_r.threshold = reg_wdata_in[9:0];
			end else if (reg_addr_in == RCB_OFF_AGGR_PER_BLT) begin
				next_r.aggr_limit = reg_wdata_in[9:0];
			end else if (reg_addr_in == RCB_OFF_SCRATCH) begin
				next_r.scratch = reg_wdata_in;
			end else if (reg_addr_in == RCB_OFF_SOFT_RESET) begin
				soft_rst = 1'b1;
			end else if (reg_addr_in == RCB_OFF_MEMORY_CLEAR) begin
				next_r.mem_clear = 1'b1;
			end else if (reg_addr_in == RCB_OFF_CONFIG_RELOAD) begin
				soft_rst      = 1'b1;
				next_r.reload = 1'b1;
			end else begin
				wr_known = 1'b0;
			end
		end

		// clear sources beyond the command location
		if (run_start_in) begin
			next_r.mem_clear = 1'b1;
		end
		if (clr_edge && hw_clear_enable_in) begin
			next_r.mem_clear = 1'b1;
		end

		// read answer one cycle after the strobe
		next_r.rvalid      = reg_rd_in;
		next_r.rdata       = reg_rd_in ? rd_word : 32'h0000_0000;
		next_r.unsupported = (reg_rd_in && !rd_known) || (reg_wr_in && !wr_known);

		// error flag: a new event in the reading cycle wins over the read clear
		if (reg_rd_in && (reg_addr_in == RCB_OFF_READOUT_STATUS)) begin
			next_r.bus_err_flag = 1'b0;
		end
		if (bus_error_in || early_end_in || next_r.unsupported) begin
			next_r.bus_err_flag = 1'b1;
		end

		// base address and multicast matching
		next_r.base       = relocation_enable_in ? r.reloc : switch_base_in;
		next_r.base_match = (bus_addr_in[31:16] == next_r.base);
		next_r.mcst_match = (r.chain_role != RCB_CHAIN_DISABLED) &&
			(bus_addr_in[31:24] == r.mcst_addr);
		next_r.header_id  = geo_mode ? r.geo_pins : r.slot_id;

		// interrupt request and acknowledge vector
		next_r.irq       = (irq_level_in != 3'b000) && (events_stored_in > r.threshold);
		next_r.irq_level = irq_level_in;
		next_r.ack_oe    = intack_in && r.irq;
		next_r.ack_data  = intack_in ? r.vector : 32'h0000_0000;

		// aggregate count per block transfer; zero limit means no limit
		if (blt_start_in) begin
			next_r.aggr_count = 10'h000;
		end else if (aggregate_done_in && (r.aggr_count != 10'h3FF)) begin
			next_r.aggr_count = r.aggr_count + 10'h001;
		end
		next_r.blt_stop = (r.aggr_limit != 10'h000) && !blt_start_in &&
			(next_r.aggr_count >= r.aggr_limit);

		// software or backplane reset returns every register to default
		if (soft_rst || sys_rst) begin
			next_r.slot_id      = RCB_RST_GEO;
			next_r.mcst_addr    = RCB_RST_MCST_ADDR;
			next_r.chain_role   = RCB_CHAIN_DISABLED;
			next_r.reloc        = RCB_RST_RELOC;
			next_r.vector       = RCB_RST_VECTOR;
			next_r.threshold    = RCB_RST_THRESHOLD;
			next_r.aggr_limit   = RCB_RST_AGGR;
			next_r.scratch      = RCB_RST_SCRATCH;
			next_r.bus_err_flag = 1'b0;
			next_r.aggr_count   = 10'h000;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// the whole state resets to constants; straps are caught after release by the sync stages
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r            <= '0;
			r.chain_role <= RCB_CHAIN_DISABLED;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// outputs, each straight from a flip-flop
	// ------------------------------------------------------------
	assign reg_rdata_out       = r.rdata;
	assign reg_rvalid_out      = r.rvalid;
	assign reg_unsupported_out = r.unsupported;
	assign header_geo_slot_identifier_out = r.header_id;
	assign base_address_out    = r.base;
	assign base_match_out      = r.base_match;
	assign mcst_match_out      = r.mcst_match;
	assign chain_role_out      = r.chain_role;
	assign intack_data_out     = r.ack_data;
	assign intack_data_oe_out  = r.ack_oe;
	assign irq_out             = r.irq;
	assign irq_level_out       = r.irq_level;
	assign aggr_limit_out      = r.aggr_limit;
	assign blt_stop_out        = r.blt_stop;
	assign memory_clear_out    = r.mem_clear;
	assign config_reload_out   = r.reload;

endmodule : rcb_register_bank

// *** tb/rcb_register_bank_properties.sv ***
// checker of register port timing, status flags and command pulses of the register bank
`timescale 1ns/1ns
module rcb_register_bank_properties
	import rcb_pkg::*;
(
	// clock and reset
	input wire logic        clk_in,
	input wire logic        resetn_in,
	// register port
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic        reg_rvalid_out,
	input wire logic        reg_unsupported_out,
	// core state and board outputs
	input wire logic [9:0]  events_stored_in,
	input wire logic        buffer_full_in,
	input wire logic        bus_error_in,
	input wire logic        early_end_in,
	input wire logic        run_start_in,
	input wire logic [2:0]  irq_level_in,
	input wire logic        irq_out,
	input wire logic [2:0]  irq_level_out,
	input wire logic        memory_clear_out,
	input wire logic        config_reload_out
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// status read and the bus error or early end source (not unsupported access), shared by several properties
	wire logic sts_rd = reg_rd_in && (reg_addr_in == RCB_OFF_READOUT_STATUS);
	wire logic err    = bus_error_in || early_end_in;

	a_rvalid_after_read: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("read answer missing");
	a_status_bits: assert property (sts_rd |=> reg_rdata_out[31:3] == 29'h0 &&
		reg_rdata_out[1:0] == {$past(buffer_full_in), $past(events_stored_in) != 10'h000})
		else $error("status bits wrong");
	a_error_sets: assert property (bus_error_in ##1 !reg_rd_in ##1 sts_rd |=> reg_rdata_out[2])
		else $error("error flag not set");
	a_error_clears: assert property (sts_rd && !err ##1 !err && !reg_rd_in && !reg_wr_in
		##1 sts_rd && !err |=> !reg_rdata_out[2])
		else $error("error flag not cleared by read");
	a_irq_disabled: assert property (irq_level_in == 3'h0 |=> !irq_out)
		else $error("interrupt with level zero");
	a_level_copy: assert property ($past(resetn_in) |-> irq_level_out == $past(irq_level_in))
		else $error("interrupt level not passed on");
	a_clear_cmd: assert property ((reg_wr_in && reg_addr_in == RCB_OFF_MEMORY_CLEAR)
		|| run_start_in |=> memory_clear_out)
		else $error("memory clear pulse missing");
	a_reload_cmd: assert property (reg_wr_in && reg_addr_in == RCB_OFF_CONFIG_RELOAD
		|=> config_reload_out)
		else $error("reload pulse missing");
	a_unmapped_read: assert property (reg_rd_in && reg_addr_in == 16'hef30
		|=> reg_unsupported_out && reg_rdata_out == 32'h0000_0000)
		else $error("unmapped read not refused");

	c_error_seen: cover property (sts_rd ##1 reg_rdata_out[2]);
	c_irq_raised: cover property (irq_out);
	c_clear_pulse: cover property (memory_clear_out);
endmodule : rcb_register_bank_properties

bind rcb_register_bank rcb_register_bank_properties chk_u (.*);

// *** tb/rcb_host_model.sv ***
// host side model issuing single word register reads and writes
`timescale 1ns/1ns
module rcb_host_model (
	// clock
	input  wire logic        clk_in,
	// register port towards the bank
	output logic             reg_wr_out,
	output logic             reg_rd_out,
	output logic      [15:0] reg_addr_out,
	output logic      [31:0] reg_wdata_out,
	input  wire logic [31:0] reg_rdata_in
);
	// idle strobes from time zero; released lines show the inverse, never a stale value
	initial begin
		reg_wr_out    = 1'b0;
		reg_rd_out    = 1'b0;
		reg_addr_out  = 16'h0000;
		reg_wdata_out = 32'h0000_0000;
	end
	// one-cycle write strobe, taken at the following edge
	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge clk_in);
		reg_wr_out    <= 1'b1;
		reg_addr_out  <= a;
		reg_wdata_out <= v;
		@(posedge clk_in);
		reg_wr_out    <= 1'b0;
		reg_addr_out  <= ~a;
		reg_wdata_out <= ~v;
	endtask : wr
	// one-cycle read strobe; data stands only in the cycle after the taking edge
	task automatic rd(input logic [15:0] a, output logic [31:0] r);
		@(posedge clk_in);
		reg_rd_out   <= 1'b1;
		reg_addr_out <= a;
		@(posedge clk_in);
		reg_rd_out   <= 1'b0;
		reg_addr_out <= ~a;
		#1;
		r = reg_rdata_in;
	endtask : rd
endmodule : rcb_host_model

// *** tb/readout_control_register_bank_tb_top.sv ***
// self-checking bench of the readout control register bank
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module readout_control_register_bank_tb_top import rcb_pkg::*; ;
	// ------------------------------------------------------------
	// stimulus, wiring and helpers
	// ------------------------------------------------------------
	logic clk_in = 0, resetn_in = 0, geo_crate_in = 0, sysreset_in = 0, hw_clear_in = 0;
	logic buffer_full_in = 0, bus_error_in = 0, early_end_in = 0, run_start_in = 0;
	logic hw_clear_enable_in = 0, relocation_enable_in = 0, intack_in = 0;
	logic blt_start_in = 0, aggregate_done_in = 0;
	logic [4:0] geo_slot_in = 0;
	logic [9:0] events_stored_in = 0;
	logic [2:0] irq_level_in = 0;
	logic [15:0] switch_base_in = 0;
	logic [31:0] bus_addr_in = 0;
	wire logic reg_wr_in, reg_rd_in;
	wire logic [15:0] reg_addr_in;
	wire logic [31:0] reg_wdata_in;
	logic [31:0] reg_rdata_out, intack_data_out, d, exp_v [7];
	logic reg_rvalid_out, reg_unsupported_out, base_match_out, mcst_match_out, irq_out;
	logic intack_data_oe_out, blt_stop_out, memory_clear_out, config_reload_out;
	logic [4:0] header_geo_slot_identifier_out;
	logic [15:0] base_address_out;
	logic [1:0] chain_role_out;
	logic [2:0] irq_level_out;
	logic [9:0] aggr_limit_out;
	logic [3:0] k;
	int n_errors = 0, comparisons = 0, seed = 32'hc63c;
	// writable registers and the bits each one keeps
	localparam logic [15:0] OFFS [7] = '{RCB_OFF_GEO_SLOT, RCB_OFF_MULTICAST, RCB_OFF_RELOCATION,
		RCB_OFF_INT_VECTOR, RCB_OFF_INT_THRESHOLD, RCB_OFF_AGGR_PER_BLT, RCB_OFF_SCRATCH};
	localparam logic [31:0] MASK [7] = '{32'h0000_001f, 32'h0000_03ff, 32'h0000_ffff,
		32'hffff_ffff, 32'h0000_03ff, 32'h0000_03ff, 32'hffff_ffff};

	rcb_register_bank dut_u (.*);
	rcb_host_model host_u (.clk_in(clk_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
		.reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out));

	always #5 clk_in = ~clk_in;

	// one edge to sample the inputs, one for the registered outputs to land
	task automatic settle;
		repeat (2) @(posedge clk_in);
		#1;
	endtask : settle
	// optionally fill every writable register at random, then read all back
	task automatic tbl(input bit wrt);
		logic [31:0] r;
		for (int i = 0; i < 7; i++) begin
			r = $random(seed);
			if (wrt) host_u.wr(OFFS[i], r);
			exp_v[i] = wrt ? (r & MASK[i]) : 32'h0000_0000;
		end
		for (int i = 0; i < 7; i++) begin
			host_u.rd(OFFS[i], r);
			`CHK("register", exp_v[i], r)
		end
	endtask : tbl
	task automatic sts(input logic [2:0] e);
		logic [31:0] r;
		host_u.rd(RCB_OFF_READOUT_STATUS, r);
		`CHK("status", {29'h0, e}, r)
	endtask : sts
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_in);
		resetn_in <= 1'b1;
		tbl(0);
		tbl(1);
		host_u.wr(RCB_OFF_SOFT_RESET, $random(seed));
		tbl(0);
		$display("test registers done");
		// error pulse then status reads: flag reported once, then cleared by the read
		@(posedge clk_in);
		{events_stored_in, buffer_full_in, bus_error_in} <= {10'h005, 2'b11};
		@(posedge clk_in);
		bus_error_in <= 1'b0;
		sts(3'b111);
		sts(3'b011);
		host_u.rd(16'hef30, d);
		`CHK("unmapped", 32'h0000_0000, d)
		`CHK("refused", 1'b1, reg_unsupported_out)
		sts(3'b111);
		@(posedge clk_in);
		{events_stored_in, buffer_full_in, early_end_in} <= {10'h000, 2'b01};
		@(posedge clk_in);
		early_end_in <= 1'b0;
		sts(3'b100);
		sts(3'b000);
		$display("test status done");
		// interrupt: strictly above threshold, level gate, vector on acknowledge
		d = $random(seed);
		host_u.wr(RCB_OFF_INT_VECTOR, d);
		host_u.wr(RCB_OFF_INT_THRESHOLD, 32'h0000_0010);
		@(posedge clk_in);
		{irq_level_in, events_stored_in} <= {3'h5, 10'h010};
		settle;
		`CHK("irq at threshold", 1'b0, irq_out)
		events_stored_in <= 10'h011;
		settle;
		`CHK("irq above", 1'b1, irq_out)
		`CHK("irq level", 3'h5, irq_level_out)
		intack_in <= 1'b1;
		settle;
		`CHK("vector", d, intack_data_out)
		`CHK("vector drive", 1'b1, intack_data_oe_out)
		{intack_in, irq_level_in} <= 4'h0;
		settle;
		`CHK("irq off", 1'b0, irq_out)
		$display("test interrupt done");
		// base address source and multicast roles
		host_u.wr(RCB_OFF_RELOCATION, 32'h0000_a5c3);
		@(posedge clk_in);
		{relocation_enable_in, bus_addr_in, switch_base_in} <= {1'b1, 32'ha5c3_0000, 16'h1234};
		settle;
		`CHK("relocated base", 16'ha5c3, base_address_out)
		`CHK("base match", 1'b1, base_match_out)
		relocation_enable_in <= 1'b0;
		settle;
		`CHK("switch base", 16'h1234, base_address_out)
		bus_addr_in <= 32'h5a00_0000;
		for (int r = 0; r < 4; r++) begin
			host_u.wr(RCB_OFF_MULTICAST, {22'h0, r[1:0], 8'h5a});
			settle;
			`CHK("role", r[1:0], chain_role_out)
			`CHK("multicast", r != 0, mcst_match_out)
		end
		// aggregate limit of three reached exactly on the third
		host_u.wr(RCB_OFF_AGGR_PER_BLT, 32'h0000_0003);
		@(posedge clk_in);
		blt_start_in <= 1'b1;
		@(posedge clk_in);
		{blt_start_in, aggregate_done_in} <= 2'b01;
		repeat (2) @(posedge clk_in);
		aggregate_done_in <= 1'b0;
		settle;
		`CHK("stop early", 1'b0, blt_stop_out)
		aggregate_done_in <= 1'b1;
		@(posedge clk_in);
		aggregate_done_in <= 1'b0;
		settle;
		`CHK("stop", 1'b1, blt_stop_out)
		`CHK("limit", 10'h003, aggr_limit_out)
		$display("test addressing done");
		// memory clear from command, run start and the hardware pin
		host_u.wr(RCB_OFF_MEMORY_CLEAR, $random(seed));
		#1 `CHK("clear cmd", 1'b1, memory_clear_out)
		host_u.rd(RCB_OFF_AGGR_PER_BLT, d);
		`CHK("kept", 32'h0000_0003, d)
		run_start_in <= 1'b1;
		@(posedge clk_in);
		run_start_in <= 1'b0;
		#1 `CHK("clear run", 1'b1, memory_clear_out)
		{hw_clear_enable_in, hw_clear_in} <= 2'b11;
		k = 4'h0;
		repeat (8) begin
			@(posedge clk_in);
			#1 k = k + {3'h0, memory_clear_out};
		end
		`CHK("clear pin", 4'h1, k)
		// slot from the backplane is read-only and feeds the header
		d = $random(seed);
		{hw_clear_in, geo_crate_in, geo_slot_in} <= {2'b01, d[4:0]};
		repeat (6) @(posedge clk_in);
		host_u.wr(RCB_OFF_GEO_SLOT, {27'h0, ~d[4:0]});
		host_u.rd(RCB_OFF_GEO_SLOT, exp_v[0]);
		`CHK("geo slot", {27'h0, d[4:0]}, exp_v[0])
		`CHK("header id", d[4:0], header_geo_slot_identifier_out)
		geo_crate_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		// reload and backplane reset both restore defaults
		tbl(1);
		host_u.wr(RCB_OFF_CONFIG_RELOAD, $random(seed));
		#1 `CHK("reload", 1'b1, config_reload_out)
		tbl(0);
		tbl(1);
		sysreset_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		sysreset_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		tbl(0);
		$display("test commands done");
		tally_and_finish;
	end

	// cut a hang short well beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk_in);
		n_errors++;
		tally_and_finish;
	end
endmodule : readout_control_register_bank_tb_top
